// ==== rtl/wwdt_pkg.sv ====
/*
 * Shared constants and types of the windowed watchdog timer: clock figures, register map,
 * field positions, reset values and the packed carriers between core and watchdog.
 * Assumes a 250 MHz system clock from which the nominal low-power RC tick is derived.
 */
package wwdt_pkg;
    // Clock figures; the RC tick period rounds down to whole system cycles.
    localparam int CLK_SYS_HZ = 250_000_000;
    localparam int LOW_POWER_RC_OSC_NOM_HZ = 32_000;
    localparam int LOW_POWER_RC_OSC_DIV_CYC = CLK_SYS_HZ / LOW_POWER_RC_OSC_NOM_HZ;

    // Counter widths and prescaler terminal counts (divide by 32 or by 128).
    localparam int PRESC_W = 7;
    localparam int POST_W = 15;
    localparam logic [6:0] PRESC_LAST_32 = 7'h1F;
    localparam logic [6:0] PRESC_LAST_128 = 7'h7F;
    localparam logic [4:0] PRESC_SHIFT_32 = 5'h05;
    localparam logic [4:0] PRESC_SHIFT_128 = 5'h07;

    // Window opening point in eighths of the period, per window size code.
    localparam logic [3:0] WIN_START_25 = 4'h6;
    localparam logic [3:0] WIN_START_37 = 4'h5;
    localparam logic [3:0] WIN_START_50 = 4'h4;
    localparam logic [3:0] WIN_START_75 = 4'h2;

    // Register map, byte addresses of aligned 32-bit words.
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_RESET_CTRL = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;

    // Reset control register bit positions.
    localparam int RCTL_IDLE_BIT = 2;
    localparam int RCTL_SLEEP_BIT = 3;
    localparam int RCTL_TIMEOUT_BIT = 4;
    localparam int RCTL_SOFT_EN_BIT = 5;

    // Interrupt status bits.
    localparam int IRQ_W = 3;
    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_WINDOW_BIT = 1;
    localparam int IRQ_WAKE_BIT = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Watchdog configuration word, bits 9:0.
    typedef struct packed {
        logic [1:0] window_size_select;
        logic config_always_enable;
        logic window_disable;
        logic unused5;
        logic prescale_select;
        logic [3:0] postscale_select;
    } wwdt_cfg_t;
    localparam wwdt_cfg_t CFG_RST = 10'h05F;

    // One-cycle event pulses from the core and clock system.
    typedef struct packed {
        logic dev_reset;
        logic clk_switch_done;
        logic power_save_sleep;
        logic power_save_idle;
        logic power_save_exit;
        logic clear_watchdog_instr;
    } wwdt_core_evt_t;

    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_IDLE} wwdt_mode_t;
endpackage : wwdt_pkg

// ==== rtl/wwdt_top.sv ====
/*
 * Windowed watchdog timer with an AXI4-Lite register slave and an interrupt.
 * Assumes core events arrive as one-cycle pulses synchronous to I_CLK_SYS, and that the
 * device reset request and wake pulses are acted upon by logic outside this block.
 */
// What this block does
// - Prescale RC tick by 32 or 128.
// - Postscaler gives sixteen ratios, 1:1 to 1:32768.
// - Device reset clears all watchdog counts.
// - Finished clock switch clears all watchdog counts.
// - Entering sleep or idle clears counts.
// - Leaving sleep or idle clears counts.
// - Clear instruction clears counts; software repeats it.
// - RC clock source runs whenever watchdog enabled.
// - Watchdog keeps counting in sleep and idle.
// - Time-out in power save wakes, no reset.
// - Always-enable bit forces watchdog on.
// - Otherwise the software enable bit decides.
// - Every device reset clears software enable.
// - Time-out flag stays set until software clears.
// - Window-disable at zero selects windowed mode.
`timescale 1ns/1ns
module wwdt_top #(
    parameter int LOW_POWER_RC_OSC_DIV = wwdt_pkg::LOW_POWER_RC_OSC_DIV_CYC
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire logic [wwdt_pkg::ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [wwdt_pkg::ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire wwdt_pkg::wwdt_core_evt_t I_CORE_EVT,
    output logic O_DEV_RESET,
    output logic O_WAKE,
    output logic O_LOW_POWER_RC_OSC_EN,
    output logic O_IRQ
);
    import wwdt_pkg::*;

    localparam int DW = $clog2(LOW_POWER_RC_OSC_DIV);

    // Post count terminal for a postscale code: 2**code - 1.
    function automatic logic [POST_W-1:0] post_last(input logic [3:0] code);
        post_last = (15'h0001 << code) - 15'h0001;
    endfunction : post_last

    // Prescaler terminal count for the prescale select bit.
    function automatic logic [PRESC_W-1:0] presc_last(input logic sel);
        presc_last = sel ? PRESC_LAST_128 : PRESC_LAST_32;
    endfunction : presc_last

    // Byte-lane merge of a write into a register word.
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        lane_merge = res;
    endfunction : lane_merge

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State.
    wwdt_cfg_t cfg_ff;
    wwdt_mode_t mode_ff;
    logic soft_en_ff;
    logic flag_to_ff;
    logic flag_sleep_ff;
    logic flag_idle_ff;
    logic [DW-1:0] div_ff;
    logic [PRESC_W-1:0] presc_ff;
    logic [POST_W-1:0] post_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_en_ff;
    logic dev_reset_ff;
    logic wake_ff;
    logic low_power_rc_osc_en_ff;
    logic irq_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode. A write lands one cycle after both address and data are held.
    wire wr_go = !awready_ff && !wready_ff && !bvalid_ff;
    wire [ADDR_W-1:0] wa = {awaddr_ff[ADDR_W-1:2], 2'b00};
    wire [ADDR_W-1:0] ra = {I_ARADDR[ADDR_W-1:2], 2'b00};
    wire wr_cfg = wr_go && wa == ADDR_CONFIG;
    wire wr_rctl = wr_go && wa == ADDR_RESET_CTRL && wstrb_ff[0];
    wire wr_ien = wr_go && wa == ADDR_IRQ_ENABLE && wstrb_ff[0];
    wire wr_iclr = wr_go && wa == ADDR_IRQ_CLEAR && wstrb_ff[0];
    wire wr_mapped = wa == ADDR_CONFIG || wa == ADDR_RESET_CTRL || wa == ADDR_COUNT
                     || wa == ADDR_IRQ_STATUS || wa == ADDR_IRQ_ENABLE || wa == ADDR_IRQ_CLEAR;
    wire [31:0] cfg_word = lane_merge({22'h00_0000, cfg_ff}, wdata_ff, wstrb_ff);
    wire [31:0] rctl_rd = {26'h000_0000, soft_en_ff, flag_to_ff, flag_sleep_ff, flag_idle_ff,
                           2'b00};
    wire rd_mapped = ra == ADDR_CONFIG || ra == ADDR_RESET_CTRL || ra == ADDR_COUNT
                     || ra == ADDR_IRQ_STATUS || ra == ADDR_IRQ_ENABLE || ra == ADDR_IRQ_CLEAR;
    wire [31:0] rd_word = (ra == ADDR_CONFIG) ? {22'h00_0000, cfg_ff} :
                          (ra == ADDR_RESET_CTRL) ? rctl_rd :
                          (ra == ADDR_COUNT) ? {10'h000, post_ff, presc_ff} :
                          (ra == ADDR_IRQ_STATUS) ? {29'h0000_0000, irq_stat_ff} :
                          (ra == ADDR_IRQ_ENABLE) ? {29'h0000_0000, irq_en_ff} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Counting chain: RC tick divider, prescaler, postscaler.
    wire wdt_en = cfg_ff.config_always_enable | soft_en_ff;
    wire low_power_rc_osc_tick = wdt_en && div_ff == DW'(LOW_POWER_RC_OSC_DIV - 1);
    wire presc_wrap = low_power_rc_osc_tick && presc_ff == presc_last(cfg_ff.prescale_select);
    wire post_wrap = presc_wrap && post_ff == post_last(cfg_ff.postscale_select);
    wire in_run = mode_ff == MODE_RUN;

    // Window check: elapsed time against the opening point, both scaled by eight.
    wire [21:0] elapsed = cfg_ff.prescale_select ? {post_ff, presc_ff}
                                                 : {2'b00, post_ff, presc_ff[4:0]};
    wire [4:0] period_exp = {1'b0, cfg_ff.postscale_select}
                            + (cfg_ff.prescale_select ? PRESC_SHIFT_128 : PRESC_SHIFT_32);
    wire [25:0] period = 26'h000_0001 << period_exp;
    wire [3:0] win_start = (cfg_ff.window_size_select == 2'b00) ? WIN_START_25 :
                           (cfg_ff.window_size_select == 2'b01) ? WIN_START_37 :
                           (cfg_ff.window_size_select == 2'b10) ? WIN_START_50 : WIN_START_75;
    wire [29:0] win_thresh = {4'h0, period} * {26'h000_0000, win_start};
    wire in_window = {5'h00, elapsed, 3'b000} >= win_thresh;

    // Core events; clear and power-save instructions only count in normal execution.
    wire clr_instr = I_CORE_EVT.clear_watchdog_instr && in_run;
    wire win_viol = clr_instr && wdt_en && !cfg_ff.window_disable && !in_window;
    wire enter_sleep = in_run && I_CORE_EVT.power_save_sleep;
    wire enter_idle = in_run && I_CORE_EVT.power_save_idle && !I_CORE_EVT.power_save_sleep;
    wire exit_ps = !in_run && I_CORE_EVT.power_save_exit;
    wire to_run = post_wrap && in_run;
    wire to_wake = post_wrap && !in_run;
    wire fire_reset = to_run || win_viol;
    wire any_reset = I_CORE_EVT.dev_reset || fire_reset;
    // A configuration write also restarts the count, so a new ratio starts from zero.
    wire clr_cnt = any_reset || I_CORE_EVT.clk_switch_done
                   || enter_sleep || enter_idle || exit_ps
                   || clr_instr || post_wrap || wr_cfg || !wdt_en;

    // Next counts; in sleep and idle the chain runs just as in normal execution.
    wire [DW-1:0] nxt_div = (clr_cnt || low_power_rc_osc_tick) ? '0 : div_ff + DW'(1);
    wire [PRESC_W-1:0] nxt_presc = clr_cnt ? '0 : presc_wrap ? '0 :
                                   low_power_rc_osc_tick ? presc_ff + 7'h01 : presc_ff;
    wire [POST_W-1:0] nxt_post = clr_cnt ? '0 : presc_wrap ? post_ff + 15'h0001 : post_ff;

    // Mode and flag next values; hardware sets win over software clears.
    wire nxt_soft_en = any_reset ? 1'b0
                       : wr_rctl ? wdata_ff[RCTL_SOFT_EN_BIT] : soft_en_ff;
    wire nxt_flag_to = post_wrap || win_viol
                       || (flag_to_ff && !(wr_rctl && !wdata_ff[RCTL_TIMEOUT_BIT]));
    wire nxt_flag_sleep = enter_sleep
                          || (flag_sleep_ff && !(wr_rctl && !wdata_ff[RCTL_SLEEP_BIT]));
    wire nxt_flag_idle = enter_idle || (flag_idle_ff && !(wr_rctl && !wdata_ff[RCTL_IDLE_BIT]));
    wire [IRQ_W-1:0] irq_events = {to_wake, win_viol, post_wrap};
    wire [IRQ_W-1:0] nxt_irq_stat = irq_events
                                    | (irq_stat_ff & ~(wr_iclr ? wdata_ff[IRQ_W-1:0] : 3'h0));
    wire [IRQ_W-1:0] nxt_irq_en = wr_ien ? wdata_ff[IRQ_W-1:0] : irq_en_ff;
    wire wwdt_mode_t nxt_mode = (any_reset || exit_ps || to_wake) ? MODE_RUN :
                                enter_sleep ? MODE_SLEEP : enter_idle ? MODE_IDLE : mode_ff;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog state registers.
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cfg_ff <= CFG_RST;
            mode_ff <= MODE_RUN;
            soft_en_ff <= 1'b0;
            flag_to_ff <= 1'b0;
            flag_sleep_ff <= 1'b0;
            flag_idle_ff <= 1'b0;
            div_ff <= '0;
            presc_ff <= '0;
            post_ff <= '0;
        end else begin
            cfg_ff <= wr_cfg ? wwdt_cfg_t'(cfg_word[9:0]) : cfg_ff;
            mode_ff <= nxt_mode;
            soft_en_ff <= nxt_soft_en;
            flag_to_ff <= nxt_flag_to;
            flag_sleep_ff <= nxt_flag_sleep;
            flag_idle_ff <= nxt_flag_idle;
            div_ff <= nxt_div;
            presc_ff <= nxt_presc;
            post_ff <= nxt_post;
        end
    end

    // Registered outputs and interrupt state; the RC enable follows the enable a cycle late.
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            dev_reset_ff <= 1'b0;
            wake_ff <= 1'b0;
            low_power_rc_osc_en_ff <= 1'b0;
            irq_ff <= 1'b0;
            irq_stat_ff <= IRQ_RST;
            irq_en_ff <= IRQ_RST;
        end else begin
            dev_reset_ff <= fire_reset;
            wake_ff <= to_wake;
            low_power_rc_osc_en_ff <= wdt_en;
            irq_ff <= |(nxt_irq_stat & nxt_irq_en);
            irq_stat_ff <= nxt_irq_stat;
            irq_en_ff <= nxt_irq_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data are taken independently, in either order.
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (I_AWVALID && awready_ff) begin
                awready_ff <= 1'b0;
                awaddr_ff <= I_AWADDR;
            end else if (bvalid_ff && I_BREADY) begin
                awready_ff <= 1'b1;
            end
            if (I_WVALID && wready_ff) begin
                wready_ff <= 1'b0;
                wdata_ff <= I_WDATA;
                wstrb_ff <= I_WSTRB;
            end else if (bvalid_ff && I_BREADY) begin
                wready_ff <= 1'b1;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (I_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read side: one read at a time, answered the cycle after the address is taken.
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (I_ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= rd_word;
        end else if (rvalid_ff && I_RREADY) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    assign O_AWREADY = awready_ff;
    assign O_WREADY = wready_ff;
    assign O_BVALID = bvalid_ff;
    assign O_BRESP = bresp_ff;
    assign O_ARREADY = arready_ff;
    assign O_RVALID = rvalid_ff;
    assign O_RRESP = rresp_ff;
    assign O_RDATA = rdata_ff;
    assign O_DEV_RESET = dev_reset_ff;
    assign O_WAKE = wake_ff;
    assign O_LOW_POWER_RC_OSC_EN = low_power_rc_osc_en_ff;
    assign O_IRQ = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks. Helpers count ticks between prescaler wraps and wraps between time-outs.
    logic [7:0] chk_ticks_ff;
    logic [15:0] chk_wraps_ff;
    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            chk_ticks_ff <= 8'h00;
            chk_wraps_ff <= 16'h0000;
        end else begin
            chk_ticks_ff <= (clr_cnt || presc_wrap) ? 8'h00 : chk_ticks_ff + {7'h00, low_power_rc_osc_tick};
            chk_wraps_ff <= clr_cnt ? 16'h0000 : chk_wraps_ff + {15'h0000, presc_wrap};
        end
    end

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RSTN);

    sequence s_counts_zero;
        div_ff == '0 && presc_ff == '0 && post_ff == '0;
    endsequence
    sequence s_run_reset;
        dev_reset_ff && flag_to_ff ##1 !dev_reset_ff;
    endsequence

    chk_presc_ratio: assert property (presc_wrap |->
        chk_ticks_ff == (cfg_ff.prescale_select ? 8'd127 : 8'd31))
        else $error("Prescaler wrapped after the wrong tick count.");
    chk_post_ratio: assert property (post_wrap |->
        chk_wraps_ff == {1'b0, post_last(cfg_ff.postscale_select)})
        else $error("Postscaler timed out after the wrong wrap count.");
    chk_devrst_clears: assert property (I_CORE_EVT.dev_reset |=>
        (s_counts_zero and !soft_en_ff))
        else $error("Device reset left counts or software enable set.");
    chk_switch_clears: assert property (I_CORE_EVT.clk_switch_done |=> s_counts_zero)
        else $error("Clock switch did not clear the counts.");
    chk_enter_clears: assert property ((enter_sleep || enter_idle) |=> (s_counts_zero
        and mode_ff != MODE_RUN))
        else $error("Power-save entry did not clear counts.");
    chk_exit_clears: assert property (exit_ps |=>
        (s_counts_zero and mode_ff == MODE_RUN))
        else $error("Power-save exit did not clear counts.");
    chk_clear_watchdog_instr_clears: assert property ((clr_instr && !win_viol) |=>
        (s_counts_zero and !dev_reset_ff))
        else $error("Clear instruction did not restart the watchdog.");
    chk_source_on: assert property (wdt_en |=> O_LOW_POWER_RC_OSC_EN)
        else $error("RC source not enabled with the watchdog.");
    chk_source_off: assert property ((!cfg_ff.config_always_enable && !soft_en_ff)
        |=> !O_LOW_POWER_RC_OSC_EN && div_ff == '0)
        else $error("Watchdog ran with both enables clear.");
    chk_sleep_counts: assert property ((!in_run && low_power_rc_osc_tick && !clr_cnt)
        |=> presc_ff != $past(presc_ff))
        else $error("Prescaler stalled in power save.");
    chk_wake_no_reset: assert property (to_wake |=> O_WAKE && !O_DEV_RESET
        && mode_ff == MODE_RUN ##1 !O_WAKE)
        else $error("Power-save time-out did not wake cleanly.");
    chk_flag_sticky: assert property ((flag_to_ff && !wr_rctl) |=> flag_to_ff)
        else $error("Time-out flag dropped without a software clear.");
    chk_window_reset: assert property (win_viol |=> s_run_reset)
        else $error("Early clear in windowed mode did not reset.");
    chk_timeout_reset: assert property (to_run |=> s_run_reset)
        else $error("Running time-out did not reset the device.");
endmodule : wwdt_top

// ==== sim/wwdt_tb.sv ====
/*
 * Self-checking bench for the windowed watchdog: AXI4-Lite register tasks, core event pulses,
 * time-out periods, wake from power save, window violation and the interrupt.
 * Assumes wwdt_top with a shortened RC tick divider and the register map of wwdt_pkg.
 */
`timescale 1ns/1ns
module testbench;
    import wwdt_pkg::*;
    localparam int DIV = 4;
    logic clk, rstn, awv, wv, brdy, arv, rrdy, awr, wr_r, bv, arr, rv, drst, wake, lpen, irq;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, d;
    logic [1:0] br, rr, resp;
    wwdt_core_evt_t evt;
    int fails, n_tests, c, e;
    logic [31:0] cfgs [3] = '{32'h0000_0040, 32'h0000_0050, 32'h0000_0043};
    int exps [3] = '{32, 128, 256};
    wwdt_top #(.LOW_POWER_RC_OSC_DIV(DIV)) dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_AWADDR(awa),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv),
        .O_WREADY(wr_r), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara),
        .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv),
        .I_RREADY(rrdy), .I_CORE_EVT(evt), .O_DEV_RESET(drst), .O_WAKE(wake),
        .O_LOW_POWER_RC_OSC_EN(lpen), .O_IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 4 ns; every wait below is bounded so a dead bus cannot hang the run.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Write: address and data offered together, each dropped once taken.
    task automatic wrt(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
            n++;
        end while (bv !== 1'b1 && n < 50);
        // Ready stays up between calls so a back-to-back write never drives it twice at once.
        if (bv !== 1'b1) begin
            fails++;
            summarize();
        end
        resp = br;
    endtask : wrt
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n = 0;
        ara <= a; arv <= 1'b1; rrdy <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            n++;
        end while (rv !== 1'b1 && n < 50);
        if (rv !== 1'b1) begin
            fails++;
            summarize();
        end
        v = rdat;
        resp = rr;
    endtask : rd
    task automatic ev(input int b);
        evt[b] <= 1'b1;
        @(posedge clk);
        evt <= '0;
    endtask : ev
    // Wait for a reset request or wake pulse; the cycle count goes to c.
    task automatic wev(input int lim);
        c = 0;
        while (drst !== 1'b1 && wake !== 1'b1 && c < lim) begin
            @(posedge clk);
            c++;
        end
        if (c >= lim) begin
            fails++;
            summarize();
        end
    endtask : wev
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        summarize();
    end
    initial begin
        rstn = 1'b0; awv = 0; wv = 0; brdy = 0; arv = 0; rrdy = 0;
        awa = '0; ara = '0; wd = '0; evt = '0; fails = 0; n_tests = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(ADDR_CONFIG, d); chk(d, 32'h0000_005F);
        rd(ADDR_RESET_CTRL, d); chk(d, 32'h0000_0000);
        chk(lpen, 1'b0);
        rd(8'h40, d); chk(d, 32'h0000_0000);
        chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
        wrt(8'h40, 32'h0000_0001);
        chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
        $display("test reset done");
        // Periods: prescale 32 or 128 times postscale ratio, in RC ticks of DIV cycles.
        wrt(ADDR_IRQ_ENABLE, 32'h0000_0001);
        chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY});
        for (int i = 0; i < 3; i++) begin
            wrt(ADDR_CONFIG, cfgs[i]);
            wrt(ADDR_RESET_CTRL, 32'h0000_0020);
            repeat (2) @(posedge clk);
            chk(lpen, 1'b1);
            e = exps[i] * DIV;
            wev(5000);
            chk(drst, 1'b1);
            chk(c > e - 10 && c < e + 8, 1'b1);
            rd(ADDR_RESET_CTRL, d); chk(d, 32'h0000_0010);
            chk(irq, 1'b1);
            wrt(ADDR_RESET_CTRL, 32'h0000_0000);
            wrt(ADDR_IRQ_CLEAR, 32'h0000_0007);
            rd(ADDR_RESET_CTRL, d); chk(d, 32'h0000_0000);
            chk(irq, 1'b0);
        end
        $display("test periods done");
        // Each clearing event: clock switch, clear, sleep in and out, idle in and out, reset.
        wrt(ADDR_CONFIG, 32'h0000_005F);
        wrt(ADDR_RESET_CTRL, 32'h0000_0020);
        foreach (cfgs[i]) c = 0;
        for (int k = 0; k < 7; k++) begin
            repeat (40) @(posedge clk);
            ev(k == 0 ? 4 : k == 1 ? 0 : k == 2 ? 3 : k == 4 ? 2 : k == 6 ? 5 : 1);
            rd(ADDR_COUNT, d); chk(d < 4, 1'b1);
        end
        rd(ADDR_RESET_CTRL, d); chk(d, 32'h0000_000C);
        wrt(ADDR_RESET_CTRL, 32'h0000_0000);
        $display("test clears done");
        // Time-out while asleep wakes without a reset request.
        wrt(ADDR_CONFIG, 32'h0000_0040);
        wrt(ADDR_RESET_CTRL, 32'h0000_0020);
        ev(3);
        wev(2000); chk({wake, drst}, 2'b10);
        rd(ADDR_RESET_CTRL, d); chk(d, 32'h0000_0038);
        rd(ADDR_IRQ_STATUS, d); chk(d, 32'h0000_0005);
        wrt(ADDR_RESET_CTRL, 32'h0000_0000);
        rd(ADDR_RESET_CTRL, d); chk(d, 32'h0000_0000);
        wrt(ADDR_IRQ_CLEAR, 32'h0000_0007);
        $display("test sleep done");
        // Windowed mode: a clear right after enabling is too early.
        wrt(ADDR_CONFIG, 32'h0000_0000);
        wrt(ADDR_RESET_CTRL, 32'h0000_0020);
        ev(0);
        wev(20); chk(drst, 1'b1);
        rd(ADDR_IRQ_STATUS, d); chk(d, 32'h0000_0002);
        wrt(ADDR_RESET_CTRL, 32'h0000_0000);
        // A clear late in the period, past the opening at six eighths, restarts without reset.
        wrt(ADDR_RESET_CTRL, 32'h0000_0020);
        repeat (105) @(posedge clk);
        ev(0);
        rd(ADDR_RESET_CTRL, d); chk(d, 32'h0000_0020);
        rd(ADDR_COUNT, d); chk(d < 4, 1'b1);
        wrt(ADDR_RESET_CTRL, 32'h0000_0000);
        // Always-enable runs with the software enable clear.
        wrt(ADDR_CONFIG, 32'h0000_00C0);
        repeat (2) @(posedge clk);
        chk(lpen, 1'b1);
        wev(1000); chk(drst, 1'b1);
        wrt(ADDR_CONFIG, 32'h0000_005F);
        repeat (2) @(posedge clk);
        chk(lpen, 1'b0);
        $display("test window done");
        summarize();
    end
endmodule : testbench
